/* File: hw/hisl_pkg.sv */
// Constants shared by the pin status and low-side override logic.
package hisl_pkg;
   // ****************************************
   // Register bus shape
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PINS_PER_BANK = 4;
   localparam int NUM_BANKS = 2;
   localparam int NUM_PINS = 8;
   localparam int NUM_LS_PINS = 3;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_BANK0_WAKE_EN = 8'h37;
   localparam logic [7:0] ADDR_BANK0_FAIL_EN = 8'h38;
   localparam logic [7:0] ADDR_BANK1_WAKE_EN = 8'h47;
   localparam logic [7:0] ADDR_BANK1_FAIL_EN = 8'h48;
   localparam logic [7:0] ADDR_BANK0_WAKE_STATUS = 8'h64;
   localparam logic [7:0] ADDR_BANK0_FAIL_STATUS = 8'h65;
   localparam logic [7:0] ADDR_BANK1_WAKE_STATUS = 8'h66;
   localparam logic [7:0] ADDR_BANK1_FAIL_STATUS = 8'h67;
   localparam logic [7:0] ADDR_LOWSIDE_OVERRIDE = 8'h72;

   // ****************************************
   // Field positions inside a bank byte
   // ****************************************
   localparam int WAKE_RISE_BIT = 0;
   localparam int WAKE_FALL_BIT = 1;
   localparam int FAIL_OPEN_BIT = 0;
   localparam int FAIL_SHORT_BIT = 1;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] OVERRIDE_PRESET = 3'h0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [7:0] PIN_PRESENT_ALL = 8'hff;
endpackage

/* File: hw/hisl_bank.sv */
// One bank of four pins: wake and fail status flags and their enables.
`timescale 1ns/1ps
module hisl_bank (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic mode_change,
   input wire logic wr_wake_en,
   input wire logic wr_fail_en,
   input wire logic wr_wake_status,
   input wire logic wr_fail_status,
   input wire logic [hisl_pkg::DATA_W-1:0] wdata,
   input wire logic [hisl_pkg::PINS_PER_BANK-1:0] rise_evt,
   input wire logic [hisl_pkg::PINS_PER_BANK-1:0] fall_evt,
   input wire logic [hisl_pkg::PINS_PER_BANK-1:0] short_evt,
   input wire logic [hisl_pkg::PINS_PER_BANK-1:0] open_evt,
   output logic [hisl_pkg::DATA_W-1:0] wake_status,
   output logic [hisl_pkg::DATA_W-1:0] fail_status,
   output logic [hisl_pkg::DATA_W-1:0] wake_enable,
   output logic [hisl_pkg::DATA_W-1:0] fail_enable,
   output logic pending
);
   import hisl_pkg::*;

   logic [DATA_W-1:0] wake_evt;
   logic [DATA_W-1:0] fail_evt;

   // ****************************************
   // Event placement
   // ****************************************
   genvar p;
   generate
      for (p = 0; p < PINS_PER_BANK; p++) begin : g_pin
         assign wake_evt[2*p+WAKE_RISE_BIT] = rise_evt[p]; // RL5
         assign wake_evt[2*p+WAKE_FALL_BIT] = fall_evt[p]; // RL5
         assign fail_evt[2*p+FAIL_OPEN_BIT] = open_evt[p]; // RL6
         assign fail_evt[2*p+FAIL_SHORT_BIT] = short_evt[p]; // RL6
      end
   endgenerate

   // ****************************************
   // Enables
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rstn || mode_change) begin
         wake_enable <= ENABLE_RESET; // RL12
         fail_enable <= ENABLE_RESET; // RL12
      end else begin
         if (wr_wake_en) begin
            wake_enable <= wdata; // RL11
         end
         if (wr_fail_en) begin
            fail_enable <= wdata; // RL11
         end
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   // A disabled source never latches, so enabling it later does not raise
   // an old event. A new event beats a clear in the same cycle.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wake_status <= STATUS_RESET;
         fail_status <= STATUS_RESET;
      end else if (mode_change) begin
         wake_status <= (wake_evt & wake_enable); // RL12
         fail_status <= (fail_evt & fail_enable); // RL12
      end else begin
         wake_status <= (wake_status & ~(wr_wake_status ? wdata : 8'h00))
                        | (wake_evt & wake_enable); // RL13 RL10 RL9
         fail_status <= (fail_status & ~(wr_fail_status ? wdata : 8'h00))
                        | (fail_evt & fail_enable); // RL13 RL10 RL9
      end
   end

   assign pending = |((wake_status & wake_enable)
                    | (fail_status & fail_enable)); // RL14
endmodule // hisl_bank

/* File: hw/hisl_top.sv */
// Pin status registers, interrupt request and low-side override bits.
// Notes on behaviour
// RL1: Override bit 1 forces that pin's low-side driver off regardless of request.
// RL2: Override bit 0 (preset) lets the low-side driver follow its control setting.
// RL3: Override bits are non-volatile and writable only under restricted access.
// RL4: Override bits of absent pins always read 0, also in the CRC image.
// RL5: Bank 0 wake status at 64h holds pin 1-4 rise/fall flags.
// RL6: Bank 0 fail status at 65h: odd bits short, even bits open load.
// RL7: Bank 1 wake status at 66h holds pin 5-8 rise/fall flags.
// RL8: Bank 1 fail status at 67h: odd bits short, even bits open load.
// RL9: A flag reads 1 while pending, 0 otherwise; all status bits read/write.
// RL10: Each edge and fault interrupt is gated by its own enable bit.
// RL11: Enable registers at 37h, 38h, 47h, 48h mirror status layout.
// RL12: Mode change reinitialises enables and interrupt flags to defaults; the code loads flags with events arriving that cycle, gated by the old enables.
// RL13: A detected event sets its flag until software writes 1 there.
// RL14: Any enabled pending flag raises the interrupt request output.
`timescale 1ns/1ps
module hisl_top #(
   parameter logic [7:0] PIN_PRESENT = 8'hff
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic [hisl_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [hisl_pkg::DATA_W-1:0] reg_wdata,
   output logic [hisl_pkg::DATA_W-1:0] reg_rdata,
   input wire logic nv_write_unlock,
   input wire logic mode_change,
   input wire logic [hisl_pkg::NUM_PINS-1:0] rise_evt,
   input wire logic [hisl_pkg::NUM_PINS-1:0] fall_evt,
   input wire logic [hisl_pkg::NUM_PINS-1:0] short_evt,
   input wire logic [hisl_pkg::NUM_PINS-1:0] open_evt,
   input wire logic [hisl_pkg::NUM_LS_PINS-1:0] lowside_request,
   output logic [hisl_pkg::NUM_LS_PINS-1:0] lowside_drive,
   output logic [hisl_pkg::DATA_W-1:0] override_crc_image,
   output logic irq_request
);
   import hisl_pkg::*;

   logic [NUM_BANKS-1:0] wr_wake_en;
   logic [NUM_BANKS-1:0] wr_fail_en;
   logic [NUM_BANKS-1:0] wr_wake_status;
   logic [NUM_BANKS-1:0] wr_fail_status;
   logic [DATA_W-1:0] wake_status [NUM_BANKS];
   logic [DATA_W-1:0] fail_status [NUM_BANKS];
   logic [DATA_W-1:0] wake_enable [NUM_BANKS];
   logic [DATA_W-1:0] fail_enable [NUM_BANKS];
   logic [NUM_BANKS-1:0] bank_pending;
   logic [NUM_LS_PINS-1:0] pin1_3_override;
   logic [NUM_LS_PINS-1:0] present_mask;
   logic [DATA_W-1:0] next_rdata;

   assign present_mask = PIN_PRESENT[NUM_LS_PINS-1:0];

   // ****************************************
   // Write decode
   // ****************************************
   assign wr_wake_en[0] = reg_wr && (reg_addr == ADDR_BANK0_WAKE_EN); // RL11
   assign wr_fail_en[0] = reg_wr && (reg_addr == ADDR_BANK0_FAIL_EN); // RL11
   assign wr_wake_en[1] = reg_wr && (reg_addr == ADDR_BANK1_WAKE_EN); // RL11
   assign wr_fail_en[1] = reg_wr && (reg_addr == ADDR_BANK1_FAIL_EN); // RL11
   assign wr_wake_status[0] = reg_wr
                              && (reg_addr == ADDR_BANK0_WAKE_STATUS); // RL5
   assign wr_fail_status[0] = reg_wr
                              && (reg_addr == ADDR_BANK0_FAIL_STATUS); // RL6
   assign wr_wake_status[1] = reg_wr
                              && (reg_addr == ADDR_BANK1_WAKE_STATUS); // RL7
   assign wr_fail_status[1] = reg_wr
                              && (reg_addr == ADDR_BANK1_FAIL_STATUS); // RL8

   // ****************************************
   // Banks
   // ****************************************
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         hisl_bank u_bank (
            .mclk(mclk),
            .rstn(rstn),
            .mode_change(mode_change),
            .wr_wake_en(wr_wake_en[b]),
            .wr_fail_en(wr_fail_en[b]),
            .wr_wake_status(wr_wake_status[b]),
            .wr_fail_status(wr_fail_status[b]),
            .wdata(reg_wdata),
            .rise_evt(rise_evt[b*PINS_PER_BANK +: PINS_PER_BANK]),
            .fall_evt(fall_evt[b*PINS_PER_BANK +: PINS_PER_BANK]),
            .short_evt(short_evt[b*PINS_PER_BANK +: PINS_PER_BANK]),
            .open_evt(open_evt[b*PINS_PER_BANK +: PINS_PER_BANK]),
            .wake_status(wake_status[b]),
            .fail_status(fail_status[b]),
            .wake_enable(wake_enable[b]),
            .fail_enable(fail_enable[b]),
            .pending(bank_pending[b])
         );
      end
   endgenerate

   // ****************************************
   // Low-side override
   // ****************************************
   // The stored copy stands for the non-volatile cell; reset loads the
   // factory preset because no programmed value is modelled here.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pin1_3_override <= OVERRIDE_PRESET; // RL2
      end else if (reg_wr && nv_write_unlock
                   && (reg_addr == ADDR_LOWSIDE_OVERRIDE)) begin // RL3
         pin1_3_override <= reg_wdata[NUM_LS_PINS-1:0]
                            & present_mask; // RL4
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         lowside_drive <= '0;
      end else begin
         lowside_drive <= lowside_request & ~pin1_3_override; // RL1 RL2
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         override_crc_image <= 8'h00;
      end else begin
         override_crc_image <= {5'h00,
                                pin1_3_override & present_mask}; // RL4
      end
   end

   // ****************************************
   // Read path and interrupt request
   // ****************************************
   always_comb begin
      unique case (reg_addr)
         ADDR_BANK0_WAKE_EN: next_rdata = wake_enable[0];
         ADDR_BANK0_FAIL_EN: next_rdata = fail_enable[0];
         ADDR_BANK1_WAKE_EN: next_rdata = wake_enable[1];
         ADDR_BANK1_FAIL_EN: next_rdata = fail_enable[1];
         ADDR_BANK0_WAKE_STATUS: next_rdata = wake_status[0]; // RL9
         ADDR_BANK0_FAIL_STATUS: next_rdata = fail_status[0]; // RL9
         ADDR_BANK1_WAKE_STATUS: next_rdata = wake_status[1]; // RL9
         ADDR_BANK1_FAIL_STATUS: next_rdata = fail_status[1]; // RL9
         ADDR_LOWSIDE_OVERRIDE: next_rdata = {5'h00, pin1_3_override};
         default: next_rdata = READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= |bank_pending; // RL14
      end
   end
endmodule // hisl_top

/* File: tb/hisl_top_sva.sv */
// Port checker for the pin status and low-side override block.
`timescale 1ns/1ps
module hisl_top_sva #(
   parameter logic [7:0] PIN_PRESENT = 8'hff
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic nv_write_unlock,
   input wire logic mode_change,
   input wire logic [7:0] rise_evt,
   input wire logic [7:0] fall_evt,
   input wire logic [7:0] short_evt,
   input wire logic [7:0] open_evt,
   input wire logic [2:0] lowside_request,
   input wire logic [2:0] lowside_drive,
   input wire logic [7:0] override_crc_image,
   input wire logic irq_request
);
   wire logic nv_ok = reg_wr && reg_addr == 8'h72 && nv_write_unlock;
   wire logic cause = |(rise_evt | fall_evt | short_evt | open_evt) || reg_wr;
   wire logic mapped = reg_addr inside {8'h37, 8'h38, 8'h47, 8'h48, 8'h64,
      8'h65, 8'h66, 8'h67, 8'h72};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_mode_only; mode_change && !reg_wr; endsequence
   sequence s_irq_quiet; ##2 !irq_request; endsequence
   chk_reset_quiet: assert property (!$past(rstn) |-> !irq_request &&
      lowside_drive == 3'h0) else $error("outputs not clear after reset");
   chk_ls_follow: assert property ($past(rstn) |-> lowside_drive ==
      ($past(lowside_request) & ~override_crc_image[2:0])) else $error("drive");
   chk_nv_write: assert property (nv_ok |-> ##2 override_crc_image[2:0] ==
      ($past(reg_wdata[2:0], 2) & PIN_PRESENT[2:0])) else $error("nv write");
   chk_nv_locked: assert property (!nv_ok |->
      ##2 $stable(override_crc_image)) else $error("override moved locked");
   chk_ovr_readback: assert property (reg_addr == 8'h72 |=>
      reg_rdata == override_crc_image) else $error("override readback wrong");
   chk_unmapped_zero: assert property (!mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_irq_cause: assert property ($rose(irq_request) |->
      $past(cause, 2)) else $error("request rose without cause");
   chk_mode_quiet: assert property (s_mode_only |-> s_irq_quiet)
      else $error("request survived mode change");
endmodule // hisl_top_sva
bind hisl_top hisl_top_sva #(.PIN_PRESENT(PIN_PRESENT)) i_hisl_top_sva (.*);

/* File: tb/hisl_mcu.sv */
// Register master model standing in for the microcontroller.
`timescale 1ns/1ps
module hisl_mcu (
   input wire logic mclk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   output logic nv_write_unlock = 1'b0
);
   // Released data goes to its inverse, so a stale byte never looks valid.
   task automatic wr(input logic [7:0] a, d, input logic un);
      {reg_wr, nv_write_unlock, reg_addr, reg_wdata} = {1'b1, un, a, d};
      @(posedge mclk) #1;
      {reg_wr, nv_write_unlock} = 2'b00;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      reg_addr = a;
      @(posedge mclk) #1;
      q = reg_rdata;
   endtask
endmodule // hisl_mcu

/* File: tb/tb_hisl_top.sv */
// Self-checking bench for the pin status and override block.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_hisl_top;
   logic [23:0] rows [10] = '{24'h37a5a5, 24'h385a5a, 24'h47c3c3,
      24'h483c3c, 24'h50ff00, 24'h720700, 24'h37ffff, 24'h38ffff,
      24'h47ffff, 24'h48ffff};
   int tests_run = 0;
   int n_mismatch = 0;
   logic mclk = 1'b0, rstn = 1'b0, mode_change = 1'b0;
   logic [7:0] rise_evt, fall_evt, short_evt, open_evt, q, ev, a;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, override_crc_image;
   logic [2:0] lowside_request = 3'h0, lowside_drive;
   logic irq_request, reg_wr, nv_write_unlock;
   logic [7:0] rdata_b, crc_b;
   logic [2:0] drive_b;
   always #50 mclk = ~mclk;
   hisl_top i_hisl_top (.*);
   hisl_mcu i_hisl_mcu (.*);
   // A variant with only pins 1 and 2 shows that absent override bits stay 0.
   hisl_top #(.PIN_PRESENT(8'h03)) i_hisl_top_b (.*, .reg_rdata(rdata_b),
      .lowside_drive(drive_b), .override_crc_image(crc_b), .irq_request());
   task automatic tally_and_finish;
      $display("checks run %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {short_evt, open_evt, fall_evt, rise_evt} = 32'h0;
      repeat (2) @(posedge mclk);
      #1 rstn = 1'b1;
      `CHK(irq_request, 1'b0)
      lowside_request = 3'h7;
      foreach (rows[i]) begin
         i_hisl_mcu.wr(rows[i][23:16], rows[i][15:8], 1'b0);
         i_hisl_mcu.rd(rows[i][23:16], q);
         `CHK(q, rows[i][7:0])
      end
      `CHK(lowside_drive, 3'h7)
      // A zero written first must leave the pending flag in place.
      for (int k = 0; k < 4; k++) begin
         for (int p = 0; p < 8; p++) begin
            ev = 8'h01 << (2 * (p % 4) + k % 2);
            a = 8'h64 + 8'(p / 4 * 2 + k / 2);
            {short_evt, open_evt, fall_evt, rise_evt} = 32'h1 << (8 * k + p);
            @(posedge mclk) #1;
            {short_evt, open_evt, fall_evt, rise_evt} = 32'h0;
            i_hisl_mcu.wr(a, 8'h00, 1'b0);
            i_hisl_mcu.rd(a, q);
            `CHK(q, ev)
            `CHK(irq_request, 1'b1)
            i_hisl_mcu.wr(a, ev, 1'b0);
            i_hisl_mcu.rd(a, q);
            `CHK(q, 8'h00)
            `CHK(irq_request, 1'b0)
         end
      end
      // A flag left pending before the mode change must not survive it.
      rise_evt = 8'h02;
      @(posedge mclk) #1;
      {mode_change, rise_evt} = 9'h100;
      @(posedge mclk) #1;
      {mode_change, rise_evt} = 9'h001;
      @(posedge mclk) #1;
      {mode_change, rise_evt} = 9'h000;
      i_hisl_mcu.rd(8'h37, q);
      `CHK(q, 8'h00)
      i_hisl_mcu.rd(8'h64, q);
      `CHK(q, 8'h00)
      `CHK(irq_request, 1'b0)
      i_hisl_mcu.wr(8'h72, 8'hff, 1'b1);
      i_hisl_mcu.rd(8'h72, q);
      `CHK(q, 8'h07)
      `CHK(lowside_drive, 3'h0)
      `CHK(override_crc_image, 8'h07)
      `CHK(rdata_b, 8'h03)
      `CHK(crc_b, 8'h03)
      `CHK(drive_b, 3'h4)
      rstn = 1'b0;
      @(posedge mclk) #1;
      rstn = 1'b1;
      i_hisl_mcu.rd(8'h72, q);
      `CHK(q, 8'h00)
      `CHK(lowside_drive, 3'h7)
      tally_and_finish;
   end
endmodule // tb_hisl_top
